//--- tape_cfg.svh
// timing, layout and reset constants for the tape word transfer control
`ifndef TAPE_CFG_SVH
`define TAPE_CFG_SVH
`define WORD_W          18
`define LINE_W          3
`define LINES_PER_WORD  6
`define MARK_W          6
`define UNIT_W          3
`define BLOCK_NUM_W     12
`define ZONE_LINES      30
`define LINE_TIME_NS    33
`define WORD_TIME_NS    200
`define CLK_NS          8
`define WORD_CYC        ((`WORD_TIME_NS) / (`CLK_NS))
`define CHAN_NUM        0
`define WC_LOC          15'h001E
`define CA_LOC          15'h001F
`define REV_PAR_INIT    6'h3F
`define MARK_ZERO       6'h00
`define MARK_ONES       6'h3F
`endif

//--- tape_pkg.sv
// types shared by both ends of the tape word transfer control
package tape_pkg;
	typedef enum logic [2:0] {
		FN_MOVE      = 3'h0,
		FN_SEARCH    = 3'h1,
		FN_READ_DATA = 3'h2,
		FN_READ_ALL  = 3'h3,
		FN_WRITE     = 3'h4
	} func_t;
	typedef enum logic [1:0] {
		CH_IDLE = 2'h0,
		CH_WC   = 2'h1,
		CH_CA   = 2'h2,
		CH_XFER = 2'h3
	} chan_state_t;
endpackage : tape_pkg

//--- tape_if.sv
// link between the tape controller and the host data channel side
`timescale 1ns/1ns
`include "tape_cfg.svh"
interface tape_if (
	input wire logic mclk,
	input wire logic nrst
);
	import tape_pkg::*;
	logic [`WORD_W-1:0]      ctl_word;
	logic                    ctl_load;
	logic [`WORD_W-1:0]      status_word;
	logic                    word_request_flag;
	logic                    block_control_flag;
	logic                    block_flag_clear;
	logic                    chan_search;
	logic                    chan_ack;
	logic                    chan_last;
	logic [`WORD_W-1:0]      wr_word;
	logic [`WORD_W-1:0]      rd_word;
	modport ctrl (
		input  mclk, nrst, ctl_word, ctl_load, block_flag_clear,
		input  chan_ack, chan_last, wr_word,
		output status_word, word_request_flag, block_control_flag,
		output chan_search, rd_word
	);
	modport host (
		input  mclk, nrst, status_word, word_request_flag,
		input  block_control_flag, chan_search, rd_word,
		output ctl_word, ctl_load, block_flag_clear, chan_ack,
		output chan_last, wr_word
	);
endinterface : tape_if

//--- tape_host_chan.sv
// host data channel end: word count and current address in core
`timescale 1ns/1ns
`include "tape_cfg.svh"
module tape_host_chan
	import tape_pkg::*;
(
	tape_if.host                  bus,
	input  wire logic             cfg_load,
	input  wire logic [`WORD_W-1:0] cfg_word,
	input  wire logic             flag_clear,
	input  wire logic             setup,
	input  wire logic [`WORD_W-1:0] setup_count,
	input  wire logic [14:0]      setup_addr,
	input  wire logic [`WORD_W-1:0] mem_rdata,
	output logic                  mem_we,
	output logic [14:0]           mem_addr,
	output logic [`WORD_W-1:0]    mem_wdata,
	output logic                  done,
	output logic                  block_irq,
	output logic [`WORD_W-1:0]    status
);
	logic [`WORD_W-1:0] wc_q;
	logic [14:0]        ca_q;
	logic [`WORD_W-1:0] wc_n;
	chan_state_t        st_q;
	logic               is_write;
	wire                mclk_w = bus.mclk;

	assign is_write = (bus.status_word[5:3] == FN_WRITE);
	assign wc_n = wc_q + 18'h00001;
	assign bus.ctl_word = cfg_word;
	assign bus.ctl_load = cfg_load;
	assign bus.block_flag_clear = flag_clear;
	assign block_irq = bus.block_control_flag;
	assign status = bus.status_word;

	// core 30 and 31 on channel 0 modelled as local copies
	always_ff @(posedge mclk_w) begin
		if (!bus.nrst) begin
			wc_q <= 18'h00000;
			ca_q <= 15'h0000;
		end else if (setup) begin
			wc_q <= (~setup_count) + 18'h00001;
			ca_q <= setup_addr - 15'h0001;
		end else if (st_q == CH_WC) begin
			wc_q <= wc_n;
			if (!bus.chan_search)
				ca_q <= ca_q + 15'h0001;
		end
	end

	always_ff @(posedge mclk_w) begin
		if (!bus.nrst)
			st_q <= CH_IDLE;
		else begin
			unique case (st_q)
				CH_IDLE: if (bus.word_request_flag && !done) st_q <= CH_WC;
				CH_WC:   st_q <= CH_CA;
				CH_CA:   st_q <= CH_XFER;
				CH_XFER: st_q <= CH_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_w) begin
		if (!bus.nrst)
			done <= 1'b0;
		else if (setup)
			done <= 1'b0;
		else if (st_q == CH_XFER && wc_q == 18'h00000)
			done <= 1'b1;
	end

	always_ff @(posedge mclk_w) begin
		if (!bus.nrst) begin
			bus.wr_word <= 18'h00000;
			mem_wdata   <= 18'h00000;
		end else if (st_q == CH_CA) begin
			bus.wr_word <= mem_rdata;
			mem_wdata   <= bus.rd_word;
		end
	end

	assign mem_addr = ca_q;
	// search stores the block number at the same, unadvanced address
	assign mem_we = (st_q == CH_XFER) && !is_write;
	assign bus.chan_ack = (st_q == CH_XFER);
	assign bus.chan_last = (st_q == CH_XFER) && (wc_q == 18'h00000);
endmodule : tape_host_chan

//--- tape_ctrl.sv
// tape controller end: word assembly, flags, mark check, block parity
`timescale 1ns/1ns
`include "tape_cfg.svh"
module tape_ctrl
	import tape_pkg::*;
(
	tape_if.ctrl                        bus,
	input  wire logic                   timing_in,
	input  wire logic [`LINE_W-1:0]     data_in,
	input  wire logic                   mark_in,
	input  wire logic                   write_enable_in,
	output logic [7:0]                  unit_sel,
	output logic                        tape_go,
	output logic                        tape_reverse,
	output logic [`LINE_W-1:0]          data_out,
	output logic                        data_out_en,
	output logic                        mark_error,
	output logic [`BLOCK_NUM_W-1:0]     block_count
);
	logic        mclk;
	logic [2:0]  tim_s_q;
	logic [8:0]  dat_s_q;
	logic [2:0]  mrk_s_q;
	logic        tim_lvl_q;
	logic        tim_rise;
	logic [2:0]  unit_q;
	func_t       func_q;
	logic        go_q;
	logic        rev_q;
	logic [2:0]  line_q;
	logic [`WORD_W-1:0] shift_q;
	logic [`WORD_W-1:0] wbuf_q;
	logic [`MARK_W-1:0] mark_q;
	logic        mark_seen_q;
	logic [`MARK_W-1:0] par_q;
	logic        in_block_q;
	logic        req_q;
	logic        bflag_q;
	logic        err_q;
	logic [`BLOCK_NUM_W-1:0] blk_q;
	logic [`MARK_W-1:0] mark_next;
	logic        mark_valid;
	logic        is_write;
	logic        word_done;
	logic        blk_start;
	logic        blk_end;
	logic        have_word_q;
	logic [4:0]  zone_q;
	logic [`LINE_W-1:0] dat_in_sync;
	logic        mrk_in_sync;

	assign mclk = bus.mclk;
	assign is_write = (func_q == FN_WRITE);

	// three-stage synchronisers; only the last two stages are compared
	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			tim_s_q <= 3'h0;
			dat_s_q <= 9'h000;
			mrk_s_q <= 3'h0;
		end else begin
			tim_s_q <= {tim_s_q[1:0], timing_in};
			dat_s_q <= {dat_s_q[5:0], data_in};
			mrk_s_q <= {mrk_s_q[1:0], mark_in};
		end
	end

	assign dat_in_sync = dat_s_q[8:6];
	assign mrk_in_sync = mrk_s_q[2];

	// level held until stages two and three agree
	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			tim_lvl_q <= 1'b0;
		else if (tim_s_q[1] == tim_s_q[2])
			tim_lvl_q <= tim_s_q[2];
	end
	assign tim_rise = (tim_s_q[1] == tim_s_q[2]) && tim_s_q[2] && !tim_lvl_q;

	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			unit_q <= 3'h0;
			func_q <= FN_MOVE;
			go_q   <= 1'b0;
			rev_q  <= 1'b0;
		end else if (bus.ctl_load) begin
			unit_q <= bus.ctl_word[2:0];
			func_q <= func_t'(bus.ctl_word[5:3]);
			go_q   <= bus.ctl_word[6];
			rev_q  <= bus.ctl_word[7];
		end
	end

	genvar u;
	generate
		for (u = 0; u < 8; u++) begin : g_unit
			assign unit_sel[u] = (unit_q == 3'(u));
		end
	endgenerate
	assign tape_go = go_q;
	assign tape_reverse = rev_q;

	// mark frame shifted one bit per line; valid codes checked per frame
	assign mark_next = {mark_q[4:0], mrk_in_sync};
	assign mark_valid = (mark_next != `MARK_ZERO) && (mark_next != `MARK_ONES);
	assign word_done = tim_rise && (line_q == 3'h5);

	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			line_q <= 3'h0;
		else if (tim_rise)
			line_q <= word_done ? 3'h0 : line_q + 3'h1;
	end

	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			mark_q <= `MARK_ZERO;
			mark_seen_q <= 1'b0;
		end else if (tim_rise) begin
			mark_q <= mark_next;
			if (word_done)
				mark_seen_q <= 1'b0;
			else if (mark_valid)
				mark_seen_q <= 1'b1;
		end
	end

	// a bad frame and a settings load in one cycle leave the error set
	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			err_q <= 1'b0;
		else if (word_done && !(mark_seen_q || mark_valid))
			err_q <= 1'b1;
		else if (bus.ctl_load)
			err_q <= 1'b0;
	end
	assign mark_error = err_q;

	// block start: 30 lines of zone seen then a data mark frame
	assign blk_start = word_done && !in_block_q && (zone_q >= 5'h05)
		&& mark_valid;
	assign blk_end = word_done && in_block_q && !mark_valid;
	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			in_block_q <= 1'b0;
			zone_q <= 5'h00;
			blk_q <= 12'h000;
		end else if (word_done) begin
			if (blk_start) begin
				in_block_q <= 1'b1;
				blk_q <= blk_q + 12'h001;
			end else if (blk_end)
				in_block_q <= 1'b0;
			if (in_block_q)
				zone_q <= 5'h00;
			else if (zone_q != 5'h1F)
				zone_q <= zone_q + 5'h01;
		end
	end
	assign block_count = blk_q;

	// read: shift in at the low end forward, high end in reverse
	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			shift_q <= 18'h00000;
		else if (tim_rise) begin
			if (is_write) begin
				if (line_q == 3'h0)
					shift_q <= rev_q ? {3'h0, wbuf_q[17:3]} : {wbuf_q[14:0], 3'h0};
				else
					shift_q <= rev_q ? {3'h0, shift_q[17:3]} : {shift_q[14:0], 3'h0};
			end else if (rev_q)
				shift_q <= {dat_in_sync, shift_q[17:3]};
			else
				shift_q <= {shift_q[14:0], dat_in_sync};
		end
	end

	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			data_out <= 3'h0;
			data_out_en <= 1'b0;
		end else if (tim_rise) begin
			data_out_en <= is_write && in_block_q && write_enable_in;
			if (line_q == 3'h0)
				data_out <= rev_q ? wbuf_q[2:0] : wbuf_q[17:15];
			else
				data_out <= rev_q ? shift_q[2:0] : shift_q[17:15];
		end
	end

	// whole host word taken in one cycle from the channel
	always_ff @(posedge mclk) begin
		if (!bus.nrst) begin
			wbuf_q <= 18'h00000;
			have_word_q <= 1'b0;
		end else if (bus.chan_ack && is_write) begin
			wbuf_q <= bus.wr_word;
			have_word_q <= 1'b1;
		end else if (word_done)
			have_word_q <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			bus.rd_word <= 18'h00000;
		else if (word_done && !is_write)
			bus.rd_word <= rev_q ? {dat_in_sync, shift_q[17:3]}
				: {shift_q[14:0], dat_in_sync};
	end

	// block parity: equivalence of all six-bit slices
	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			par_q <= `REV_PAR_INIT;
		else if (blk_start)
			par_q <= `REV_PAR_INIT;
		else if (bus.chan_ack && in_block_q && is_write)
			par_q <= par_q ^ bus.wr_word[17:12] ^ bus.wr_word[11:6]
				^ bus.wr_word[5:0];
	end

	// request set on word boundary wins over channel completion
	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			req_q <= 1'b0;
		else if (word_done && func_q != FN_MOVE
			&& (blk_start || (in_block_q && !blk_end)))
			req_q <= 1'b1;
		else if (bus.chan_ack || bus.ctl_load)
			req_q <= 1'b0;
	end
	assign bus.word_request_flag = req_q;
	assign bus.chan_search = (func_q == FN_SEARCH);

	always_ff @(posedge mclk) begin
		if (!bus.nrst)
			bflag_q <= 1'b0;
		else if (blk_start || blk_end)
			bflag_q <= 1'b1;
		else if (bus.block_flag_clear)
			bflag_q <= 1'b0;
	end
	assign bus.block_control_flag = bflag_q;

	// par_q keeps the plain xor; status shows its complement, the
	// equivalence of the reverse character and every slice
	assign bus.status_word = {~par_q, have_word_q, err_q, req_q, bflag_q,
		rev_q, go_q, func_q, unit_q};
endmodule : tape_ctrl

//--- tape_assertions.sv
// concurrent checks on the link between the two tape transfer ends
`timescale 1ns/1ns
`include "tape_cfg.svh"
module tape_assertions
	import tape_pkg::*;
(
	input wire logic               mclk,
	input wire logic               nrst,
	input wire logic [`WORD_W-1:0] ctl_word,
	input wire logic               ctl_load,
	input wire logic [`WORD_W-1:0] status_word,
	input wire logic               word_request_flag,
	input wire logic               block_control_flag,
	input wire logic               block_flag_clear,
	input wire logic               chan_search,
	input wire logic               chan_ack,
	input wire logic               chan_last
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_req_served;
		word_request_flag ##3 chan_ack;
	endsequence
	property p_req_hold;
		word_request_flag && !chan_ack && !ctl_load |=> word_request_flag;
	endproperty
	property p_req_drop;
		s_req_served |=> !word_request_flag;
	endproperty
	property p_ack_cause;
		chan_ack |-> $past(word_request_flag, 3);
	endproperty
	property p_req_func;
		$rose(word_request_flag) |-> status_word[5:3] != FN_MOVE;
	endproperty
	property p_blk_hold;
		block_control_flag && !block_flag_clear |=> block_control_flag;
	endproperty
	property p_ctl_load;
		ctl_load |=> status_word[7:0] == $past(ctl_word[7:0]);
	endproperty
	property p_status;
		status_word[9:8] == {word_request_flag, block_control_flag};
	endproperty
	property p_search;
		chan_search == (status_word[5:3] == FN_SEARCH);
	endproperty
	property p_last;
		chan_last |-> chan_ack;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request dropped before service");
	a_req_drop: assert property (p_req_drop)
		else $error("request kept after service");
	a_ack_cause: assert property (p_ack_cause)
		else $error("transfer without request");
	a_req_func: assert property (p_req_func)
		else $error("request while moving only");
	a_blk_hold: assert property (p_blk_hold)
		else $error("block flag lost");
	a_ctl_load: assert property (p_ctl_load)
		else $error("settings not loaded");
	a_status: assert property (p_status)
		else $error("status flags differ");
	a_search: assert property (p_search)
		else $error("search level wrong");
	a_last: assert property (p_last)
		else $error("last without transfer");
endmodule : tape_assertions

//--- tape_block_word_transfer_control_tb.sv
// self-checking bench: both ends joined, tape and core modelled here
`timescale 1ns/1ns
`include "tape_cfg.svh"
module tape_block_word_transfer_control_tb;
	import tape_pkg::*;
	logic               mclk, nrst, tim, mark, wen, rev;
	logic               cfg_load, flag_clear, setup, mem_we, done;
	logic               block_irq, dout_en, merr, tgo, trev;
	logic [2:0]         din, dout;
	logic [7:0]         unit_sel;
	logic [11:0]        bcnt;
	logic [14:0]        setup_addr, mem_addr;
	logic [17:0]        cfg_word, setup_count, mem_rdata, mem_wdata, status;
	logic [17:0]        mem [16];
	logic [17:0]        wq [$];
	logic [14:0]        aq [$];
	int                 tq [$];
	int                 fails, checks, irqs, cyc, oen;
	tape_if bus_if (.mclk(mclk), .nrst(nrst));
	tape_ctrl tape_ctrl_inst (.bus(bus_if), .timing_in(tim), .data_in(din),
		.mark_in(mark), .write_enable_in(wen), .unit_sel(unit_sel),
		.tape_go(tgo), .tape_reverse(trev), .data_out(dout),
		.data_out_en(dout_en), .mark_error(merr), .block_count(bcnt));
	tape_host_chan tape_host_chan_inst (.bus(bus_if), .cfg_load(cfg_load),
		.cfg_word(cfg_word), .flag_clear(flag_clear), .setup(setup),
		.setup_count(setup_count), .setup_addr(setup_addr),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .done(done), .block_irq(block_irq),
		.status(status));
	tape_assertions tape_assertions_inst (.mclk(mclk), .nrst(nrst),
		.ctl_word(bus_if.ctl_word), .ctl_load(bus_if.ctl_load),
		.status_word(bus_if.status_word), .chan_ack(bus_if.chan_ack),
		.word_request_flag(bus_if.word_request_flag),
		.block_control_flag(bus_if.block_control_flag),
		.block_flag_clear(bus_if.block_flag_clear),
		.chan_search(bus_if.chan_search), .chan_last(bus_if.chan_last));
	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	always_comb mem_rdata = mem[mem_addr[3:0]];
	always @(posedge mclk) begin
		cyc++;
		if (dout_en)
			oen++;
		if (mem_we) begin
			wq.push_back(mem_wdata);
			aq.push_back(mem_addr);
			tq.push_back(cyc);
		end
	end
	// software side: count each block interrupt and clear it at once
	always begin
		@(posedge mclk);
		#1;
		if (block_irq && !flag_clear)
			irqs++;
		flag_clear = block_irq && !flag_clear;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic end_of_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic cfg(input logic [17:0] w);
		cfg_word = w;
		cfg_load = 1;
		tick(1);
		cfg_load = 0;
	endtask : cfg
	task automatic arm(input logic [17:0] n, input logic [14:0] a);
		setup_count = n;
		setup_addr = a;
		setup = 1;
		tick(1);
		setup = 0;
	endtask : arm
	// one line is 16 clocks, about four times the 33 ns of LINE_TIME_NS, but still paced
	// only by the timing pulses
	task automatic frame(input logic [17:0] w, input logic [5:0] mk,
		output logic [17:0] o);
		for (int i = 0; i < 6; i++) begin
			din = rev ? w[3*i+:3] : w[15-3*i+:3];
			mark = mk[5-i];
			tick(4);
			tim = 1;
			tick(4);
			tim = 0;
			tick(8);
			o = rev ? {dout, o[17:3]} : {o[14:0], dout};
		end
	endtask : frame
	// mark 2A is its own complement obverse, so it reads alike both ways
	task automatic block(input logic [17:0] w [4], output logic [17:0] o [4]);
		logic [17:0] z;
		for (int i = 0; i < 5; i++) frame('0, 6'h00, z);
		for (int i = 0; i < 4; i++) frame(w[i], 6'h2A, o[i]);
		for (int i = 0; i < 5; i++) frame('0, 6'h00, z);
	endtask : block
	task automatic t_units;
		logic [7:0] e;
		for (int u = 0; u < 8; u++) begin
			e = {u[1], u[0], 3'(u % 5), 3'(u)};
			cfg({10'h0, e});
			tick(1);
			chk(unit_sel, 8'h01 << u);
			chk(merr, 0);
			chk(status[7:0], e);
			chk({tgo, trev}, {e[6], e[7]});
		end
		$display("units test done");
	endtask : t_units
	task automatic t_write;
		logic [17:0] w [4] = '{18'h2A5C3, 18'h1F00E, 18'h0, 18'h0};
		logic [17:0] o [4];
		logic [5:0]  p;
		logic        ok;
		rev = 0;
		wen = 1;
		irqs = 0;
		oen = 0;
		mem[5] = w[0];
		mem[6] = w[1];
		cfg(18'h00060);
		arm(18'h2, 15'h5);
		block(w, o);
		ok = 0;
		p = ~(6'h3F ^ w[0][17:12] ^ w[0][11:6] ^ w[0][5:0]
			^ w[1][17:12] ^ w[1][11:6] ^ w[1][5:0]);
		for (int i = 0; i < 3; i++)
			if (o[i] === w[0] && o[i+1] === w[1])
				ok = 1;
		chk(ok, 1);
		chk(oen, 384);
		chk(merr, 1);
		chk(status[17:12], p);
		chk(done, 1);
		chk(irqs, 2);
		$display("write test done");
	endtask : t_write
	task automatic t_read(input logic r, input logic [2:0] f);
		logic [17:0] w [4] = '{18'h2A5C3, 18'h1F00E, 18'h3C3C3, 18'h0F1E2};
		logic [17:0] o [4];
		logic        ok;
		rev = r;
		wen = 0;
		irqs = 0;
		wq.delete();
		aq.delete();
		tq.delete();
		oen = 0;
		cfg({10'h0, r, 1'b1, f, 3'h2});
		arm(18'h2, 15'h8);
		block(w, o);
		chk(oen, 0);
		ok = 0;
		for (int i = 0; i < 3; i++)
			if (wq[0] === w[i] && wq[1] === w[i+1])
				ok = 1;
		chk(wq.size(), 2);
		chk(tq[1] - tq[0], 96);
		chk(irqs, 2);
		if (f == FN_SEARCH)
			chk(aq[1], aq[0]);
		else begin
			chk(ok, 1);
			chk({aq[0], aq[1]}, {15'h8, 15'h9});
		end
		$display("read test done");
	endtask : t_read
	task automatic t_move;
		logic [17:0] o [4];
		rev = 0;
		wq.delete();
		cfg(18'h00040);
		arm(18'h2, 15'h8);
		block('{default: 18'h15555}, o);
		chk(wq.size(), 0);
		chk(bcnt, 12'h005);
		$display("move test done");
	endtask : t_move
	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		end_of_test();
	end
	initial begin
		{nrst, tim, din, mark, wen, rev, cfg_load, flag_clear} = '0;
		{setup, cfg_word, setup_count, setup_addr} = '0;
		{fails, checks, irqs, cyc, oen} = '0;
		#1;
		tick(16);
		nrst = 1;
		t_write();
		t_units();
		t_read(0, FN_READ_DATA);
		t_read(1, FN_READ_ALL);
		t_read(0, FN_SEARCH);
		t_move();
		end_of_test();
	end
endmodule : tape_block_word_transfer_control_tb
